// *** swcr_pkg.sv ***
package swcr_pkg;

  // register index on the documented 7-bit address
  localparam logic [6:0] ADDR_PAYLOAD3 = 7'h30;
  localparam logic [6:0] ADDR_PAYLOAD2 = 7'h31;
  localparam logic [6:0] ADDR_PAYLOAD1 = 7'h32;
  localparam logic [6:0] ADDR_PAYLOAD0 = 7'h33;
  localparam logic [6:0] ADDR_TOL_CFG = 7'h34;
  localparam logic [6:0] ADDR_TRIM_LOW = 7'h38;
  localparam logic [6:0] ADDR_OPT_TRIM_HIGH = 7'h39;
  localparam logic [6:0] ADDR_CAL_HIGH = 7'h3A;

  // tolerance configuration field positions
  localparam int TOL_RSVD_HI = 7;
  localparam int TOL_RSVD_LO = 6;
  localparam int TOL_SUPPRESS_BIT = 5;
  localparam int TOL_BYPASS_BIT = 4;
  localparam int TOL_FILT_HI = 3;
  localparam int TOL_FILT_LO = 1;
  localparam int TOL_ENABLE_BIT = 0;

  // options register field positions
  localparam int OPT_RX_SEL_BIT = 7;
  localparam int OPT_RSVD_HI = 6;
  localparam int OPT_RSVD_LO = 5;
  localparam int OPT_TRIM_HI = 4;
  localparam int OPT_TRIM_LO = 0;

  // reset values
  localparam logic [7:0] RST_PAYLOAD = 8'h00;
  localparam logic [7:0] RST_TOL_CFG = 8'h00;
  localparam logic [7:0] RST_TRIM_LOW = 8'h00;
  localparam logic [4:0] RST_TRIM_HIGH = 5'h00;
  localparam logic RST_RX_SEL = 1'b0;
  localparam logic [7:0] RSVD_READ = 8'h00;

  // trim unlock code
  localparam logic [1:0] TRIM_UNLOCK = 2'h3;

  // dominant filter timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int FILT_STEP_NS = 50;
  localparam int FILT_LONG_NS = 775;
  localparam logic [2:0] FILT_LONG_CODE = 3'h7;
  localparam int FILT_STEP_CYC = (FILT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_LONG_CYC = (FILT_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] payload_byte_three;
    logic [7:0] payload_byte_two;
    logic [7:0] payload_byte_one;
    logic [7:0] payload_byte_zero;
  } swcr_payload_t;

  typedef struct packed {
    logic error_counter_active;
    logic analog_filter_bypass;
    logic [2:0] dominant_filter_time;
    logic [4:0] dominant_filter_cycles;
    logic tolerant_mode_enable;
  } swcr_tol_t;

  typedef struct packed {
    logic [12:0] oscillator_trim_value;
    logic wake_receiver_select;
  } swcr_osc_t;

endpackage

// *** swcr_regs.sv ***
// Behaviour
// RULE_01 - payload bytes are full read-write, reset zero
// RULE_02 - reserved bits ignore writes, read zero
// RULE_03 - suppress counter only with tolerant mode on
// RULE_04 - silence expiry clears the suppress bit
// RULE_05 - bypass bit routes around analog filter
// RULE_06 - dominant filter independent of the bypass
// RULE_07 - filter codes 50 ns steps, 111 is 775 ns
// RULE_08 - bit zero enables tolerant mode
// RULE_09 - trim writes only with unlock code 11
// RULE_10 - thirteen trim bits split over two registers
// RULE_11 - fine trim bits give 32 monotonic steps
// RULE_12 - software leaves temperature trim bits alone
// RULE_13 - receiver select bit, unlock code 11 only
// RULE_14 - software prefers the low-power receiver
// RULE_15 - software rewrites coarse trim unchanged
// RULE_16 - calibration high byte is read-only
`timescale 1ns/100ps
module swcr_regs
  import swcr_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic clk_en,
  // register access from the serial decoder
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  // device state
  input wire logic [1:0] trim_enable,
  input wire logic silence_expired,
  input wire logic [7:0] calibration_high_byte,
  // configuration to frame matching and analog
  output swcr_payload_t payload,
  output swcr_tol_t tolerance,
  output swcr_osc_t oscillator
);

  logic [7:0] payload_q [4];
  logic error_counter_suppress;
  logic analog_filter_bypass;
  logic [2:0] dominant_filter_time;
  logic tolerant_mode_enable;
  logic [7:0] trim_low;
  logic [4:0] trim_high;
  logic wake_receiver_select;

  // decode function, used by the write paths only; the read path decodes with a case
  function automatic logic hit(input logic [6:0] addr, input logic [6:0] target);
    hit = (addr == target);
  endfunction

  function automatic logic [4:0] filter_cycles(input logic [2:0] code);
    logic [4:0] steps;
    steps = 5'({2'h0, code} + 5'h01);
    if (code == FILT_LONG_CODE)
      filter_cycles = 5'(FILT_LONG_CYC);
    else
      filter_cycles = 5'(steps * 5'(FILT_STEP_CYC));
  endfunction

  wire logic step = clk_en;
  wire logic wr_tol = step && reg_wr && hit(reg_addr, ADDR_TOL_CFG);
  wire logic unlocked = (trim_enable == TRIM_UNLOCK);
  wire logic wr_trim_low = step && reg_wr && unlocked && hit(reg_addr, ADDR_TRIM_LOW); // see RULE_09
  wire logic wr_opt = step && reg_wr && unlocked && hit(reg_addr, ADDR_OPT_TRIM_HIGH); // see RULE_09
  wire logic silence_clear = step && silence_expired;
  wire logic [6:0] payload_addr [4];
  assign payload_addr[0] = ADDR_PAYLOAD0;
  assign payload_addr[1] = ADDR_PAYLOAD1;
  assign payload_addr[2] = ADDR_PAYLOAD2;
  assign payload_addr[3] = ADDR_PAYLOAD3;

  // payload match bytes
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_payload
      wire logic wr_byte = step && reg_wr && hit(reg_addr, payload_addr[gi]);
      always_ff @(posedge clk or negedge resetn)
      begin
        if (!resetn)
          payload_q[gi] <= RST_PAYLOAD; // see RULE_01
        else if (wr_byte)
          payload_q[gi] <= reg_wdata; // see RULE_01
      end
    end
  endgenerate

  // tolerance configuration; hardware clear beats a same-cycle software set
  wire logic next_suppress = silence_clear ? 1'b0 : // see RULE_04
                             (wr_tol ? reg_wdata[TOL_SUPPRESS_BIT] : error_counter_suppress);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      error_counter_suppress <= RST_TOL_CFG[TOL_SUPPRESS_BIT];
    else
      error_counter_suppress <= next_suppress; // see RULE_04
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      analog_filter_bypass <= RST_TOL_CFG[TOL_BYPASS_BIT];
      dominant_filter_time <= RST_TOL_CFG[TOL_FILT_HI:TOL_FILT_LO];
      tolerant_mode_enable <= RST_TOL_CFG[TOL_ENABLE_BIT];
    end
    else if (wr_tol)
    begin
      analog_filter_bypass <= reg_wdata[TOL_BYPASS_BIT]; // see RULE_05
      dominant_filter_time <= reg_wdata[TOL_FILT_HI:TOL_FILT_LO]; // see RULE_07
      tolerant_mode_enable <= reg_wdata[TOL_ENABLE_BIT]; // see RULE_08
    end
  end

  // oscillator trim, low byte
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      trim_low <= RST_TRIM_LOW;
    else if (wr_trim_low)
      trim_low <= reg_wdata; // see RULE_10
  end

  // options: receiver select and coarse trim share one write
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      trim_high <= RST_TRIM_HIGH;
      wake_receiver_select <= RST_RX_SEL;
    end
    else if (wr_opt)
    begin
      trim_high <= reg_wdata[OPT_TRIM_HI:OPT_TRIM_LO]; // see RULE_10
      wake_receiver_select <= reg_wdata[OPT_RX_SEL_BIT]; // see RULE_13
    end
  end

  // read image; reserved positions tied low
  wire logic [7:0] tol_image = {2'h0, error_counter_suppress, analog_filter_bypass,
                                dominant_filter_time, tolerant_mode_enable}; // see RULE_02
  wire logic [7:0] opt_image = {wake_receiver_select, 2'h0, trim_high}; // see RULE_02

  logic [7:0] read_mux;
  always_comb
  begin
    read_mux = RSVD_READ;
    case (reg_addr)
      ADDR_PAYLOAD3: read_mux = payload_q[3];
      ADDR_PAYLOAD2: read_mux = payload_q[2];
      ADDR_PAYLOAD1: read_mux = payload_q[1];
      ADDR_PAYLOAD0: read_mux = payload_q[0];
      ADDR_TOL_CFG: read_mux = tol_image;
      ADDR_TRIM_LOW: read_mux = trim_low;
      ADDR_OPT_TRIM_HIGH: read_mux = opt_image;
      ADDR_CAL_HIGH: read_mux = calibration_high_byte; // see RULE_16
      default: read_mux = RSVD_READ;
    endcase
  end

  // read data registered so it is stable for the serial shifter
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata <= RSVD_READ;
      reg_rvalid <= 1'b0;
    end
    else if (step)
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= read_mux;
    end
  end

  // configuration outputs
  assign payload.payload_byte_three = payload_q[3];
  assign payload.payload_byte_two = payload_q[2];
  assign payload.payload_byte_one = payload_q[1];
  assign payload.payload_byte_zero = payload_q[0];
  assign tolerance.error_counter_active = !(error_counter_suppress && tolerant_mode_enable); // see RULE_03
  assign tolerance.analog_filter_bypass = analog_filter_bypass; // see RULE_05
  assign tolerance.dominant_filter_time = dominant_filter_time;
  // filter length never looks at the bypass: it sits after the analog path
  assign tolerance.dominant_filter_cycles = filter_cycles(dominant_filter_time); // see RULE_06
  assign tolerance.tolerant_mode_enable = tolerant_mode_enable; // see RULE_08
  // fine steps are bits 4:0, so a plain binary value keeps them monotonic
  assign oscillator.oscillator_trim_value = {trim_high, trim_low}; // see RULE_11
  assign oscillator.wake_receiver_select = wake_receiver_select; // see RULE_13

  // checks
  payload_write_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_01
    (clk_en && reg_wr && reg_addr == ADDR_PAYLOAD0) |=> payload.payload_byte_zero == $past(reg_wdata))
    else $error("payload byte zero missed its write");

  // bit 5 of the tolerance image is live, so each register gets its own reserved mask
  reserved_zero_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_02
    (clk_en && reg_rd && reg_addr == ADDR_TOL_CFG)
    |=> reg_rvalid && reg_rdata[7:6] == 2'h0)
    else $error("tolerance reserved bits read back nonzero");

  reserved_opt_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_02
    (clk_en && reg_rd && reg_addr == ADDR_OPT_TRIM_HIGH)
    |=> reg_rvalid && reg_rdata[6:5] == 2'h0)
    else $error("options reserved bits read back nonzero");

  counter_gate_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_03
    !tolerance.error_counter_active |-> (error_counter_suppress && tolerance.tolerant_mode_enable))
    else $error("error counter suppressed without tolerant mode");

  silence_clear_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_04
    (clk_en && silence_expired) |=> !error_counter_suppress && tolerance.error_counter_active)
    else $error("silence expiry left suppress bit set");

  bypass_follow_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_05
    (clk_en && reg_wr && reg_addr == ADDR_TOL_CFG) |=> tolerance.analog_filter_bypass == $past(reg_wdata[4]))
    else $error("bypass bit did not follow its write");

  filter_hold_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_06
    $changed(tolerance.analog_filter_bypass) && $stable(tolerance.dominant_filter_time)
    |-> $stable(tolerance.dominant_filter_cycles))
    else $error("dominant filter moved with the bypass");

  filter_long_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_07
    tolerance.dominant_filter_time == 3'h7 |-> tolerance.dominant_filter_cycles == 5'h10)
    else $error("code seven does not give 775 ns");

  filter_step_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_07
    tolerance.dominant_filter_time != 3'h7
    |-> tolerance.dominant_filter_cycles == {2'h0, tolerance.dominant_filter_time} + 5'h01)
    else $error("filter code does not give 50 ns steps");

  tolerant_enable_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_08
    (clk_en && reg_wr && reg_addr == ADDR_TOL_CFG && !silence_expired)
    |=> tolerance.tolerant_mode_enable == $past(reg_wdata[0]) && error_counter_suppress == $past(reg_wdata[5]))
    else $error("tolerance register write lost");

  trim_locked_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_09
    (trim_enable != 2'h3 || !reg_wr || !clk_en) |=> $stable(oscillator))
    else $error("trim changed while locked");

  trim_split_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_10
    (clk_en && reg_wr && trim_enable == 2'h3 && reg_addr == ADDR_OPT_TRIM_HIGH)
    |=> oscillator.oscillator_trim_value[12:8] == $past(reg_wdata[4:0])
        && oscillator.wake_receiver_select == $past(reg_wdata[7])) // see RULE_13
    else $error("options write not placed in trim bits 12:8");

  cal_readonly_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_16
    (clk_en && reg_rd && reg_addr == ADDR_CAL_HIGH) |=> reg_rdata == $past(calibration_high_byte))
    else $error("calibration byte read wrong");

  payload_three_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_01
    (clk_en && reg_wr && reg_addr == ADDR_PAYLOAD3)
    |=> payload.payload_byte_three == $past(reg_wdata))
    else $error("payload byte three missed its write");

  payload_two_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_01
    (clk_en && reg_wr && reg_addr == ADDR_PAYLOAD2)
    |=> payload.payload_byte_two == $past(reg_wdata))
    else $error("payload byte two missed its write");

  payload_one_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_01
    (clk_en && reg_wr && reg_addr == ADDR_PAYLOAD1)
    |=> payload.payload_byte_one == $past(reg_wdata))
    else $error("payload byte one missed its write");

  payload_hold_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_01
    !(clk_en && reg_wr && reg_addr == ADDR_PAYLOAD3)
    |=> $stable(payload.payload_byte_three))
    else $error("payload byte three moved without a write");

  state_freeze_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_01
    !clk_en
    |=> $stable(payload) && $stable(oscillator) && $stable(reg_rvalid) && $stable(reg_rdata))
    else $error("state moved while the clock enable was low");

  rvalid_pulse_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_02
    (clk_en && !reg_rd)
    |=> !reg_rvalid)
    else $error("read valid stood without a read");

  rdata_hold_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_02
    !(clk_en && reg_rd)
    |=> $stable(reg_rdata))
    else $error("read data moved without a read");

  suppress_on_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_03
    (error_counter_suppress && tolerance.tolerant_mode_enable)
    |-> !tolerance.error_counter_active)
    else $error("error counter left active while suppressed");

  suppress_off_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_03
    !error_counter_suppress
    |-> tolerance.error_counter_active)
    else $error("error counter stopped without suppress bit");

  silence_wins_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_04
    (clk_en && silence_expired && reg_wr && reg_addr == ADDR_TOL_CFG && reg_wdata[5])
    |=> !error_counter_suppress)
    else $error("software set beat the silence clear");

  bypass_hold_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_05
    !(clk_en && reg_wr && reg_addr == ADDR_TOL_CFG)
    |=> $stable(tolerance.analog_filter_bypass))
    else $error("bypass bit moved without a write");

  filter_free_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_06
    $stable(tolerance.dominant_filter_time)
    |-> $stable(tolerance.dominant_filter_cycles))
    else $error("dominant filter length moved on its own");

  filter_write_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_07
    (clk_en && reg_wr && reg_addr == ADDR_TOL_CFG)
    |=> tolerance.dominant_filter_time == $past(reg_wdata[3:1]))
    else $error("filter code not taken from bits 3:1");

  enable_hold_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_08
    !(clk_en && reg_wr && reg_addr == ADDR_TOL_CFG)
    |=> $stable(tolerance.tolerant_mode_enable))
    else $error("tolerant mode moved without a write");

  trim_low_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_09
    (clk_en && reg_wr && trim_enable == 2'h3 && reg_addr == ADDR_TRIM_LOW)
    |=> oscillator.oscillator_trim_value[7:0] == $past(reg_wdata))
    else $error("unlocked trim low write lost");

  receiver_locked_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_13
    (trim_enable != 2'h3 || !clk_en)
    |=> $stable(oscillator.wake_receiver_select))
    else $error("receiver select changed while locked");

  cal_ignore_a: assert property (@(posedge clk) disable iff (!resetn) // see RULE_16
    (clk_en && reg_wr && reg_addr == ADDR_CAL_HIGH && !silence_expired)
    |=> $stable(oscillator) && $stable(payload) && $stable(tolerance))
    else $error("write to calibration byte changed state");

endmodule

// *** swcr_testbench.sv ***
`timescale 1ns/100ps
module testbench
  import swcr_pkg::*;
;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [1:0] te;
    logic [7:0] exp;
  } swcr_row_t;
  // clock, reset, enable
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic clk_en = 1'b1;
  // register access
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  // device state
  logic [1:0] trim_enable = 2'h0;
  logic silence_expired = 1'b0;
  logic [7:0] calibration_high_byte = 8'h6C;
  // configuration outputs
  swcr_payload_t payload;
  swcr_tol_t tolerance;
  swcr_osc_t oscillator;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  // locked trim rows come before unlocked ones, so the reset value shows through
  swcr_row_t rows [11] = '{'{7'h30, 8'hA5, 2'h0, 8'hA5}, '{7'h31, 8'h5A, 2'h0, 8'h5A},
    '{7'h32, 8'hFF, 2'h0, 8'hFF}, '{7'h33, 8'h81, 2'h0, 8'h81}, '{7'h34, 8'hFF, 2'h0, 8'h3F},
    '{7'h38, 8'hC3, 2'h0, 8'h00}, '{7'h38, 8'hC3, 2'h3, 8'hC3}, '{7'h39, 8'hFF, 2'h2, 8'h00},
    '{7'h39, 8'hFF, 2'h3, 8'h9F}, '{7'h3A, 8'hFF, 2'h3, 8'h6C}, '{7'h3F, 8'hFF, 2'h3, 8'h00}};

  swcr_regs i_dut (
    .clk(clk), .resetn(resetn), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .trim_enable(trim_enable), .silence_expired(silence_expired),
    .calibration_high_byte(calibration_high_byte),
    .payload(payload), .tolerance(tolerance), .oscillator(oscillator)
  );

  initial
  begin
    forever #25 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // all tasks except the timeout's end_sim call are entered 5 ns after a rising edge and leave at the same phase
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic [1:0] te);
    reg_addr = a;
    reg_wdata = d;
    trim_enable = te;
    reg_wr = 1'b1;
    @(posedge clk);
    #5;
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #5;
    reg_rd = 1'b0;
    chk("reg_rvalid", reg_rvalid, 1'b1);
    chk("reg_rdata", reg_rdata, e);
  endtask

  task automatic chk_tol(input logic act, input logic [2:0] code, input logic [4:0] cyc);
    chk("error_counter_active", tolerance.error_counter_active, act);
    chk("dominant_filter_time", tolerance.dominant_filter_time, code);
    chk("dominant_filter_cycles", tolerance.dominant_filter_cycles, cyc);
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      error_cnt++;
      end_sim();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk);
    #5;
    resetn = 1'b1;
    chk_tol(1'b1, 3'h0, 5'h01);
    chk("payload", payload, 32'h0);
    rd(7'h34, 8'h00);
    $display("test reset done");
    foreach (rows[i])
    begin
      wr(rows[i].addr, rows[i].wdata, rows[i].te);
      rd(rows[i].addr, rows[i].exp);
    end
    chk("payload", payload, 32'hA55AFF81);
    chk("trim", oscillator.oscillator_trim_value, 13'h1FC3);
    chk("receiver", oscillator.wake_receiver_select, 1'b1);
    chk("bypass", tolerance.analog_filter_bypass, 1'b1);
    chk("tolerant", tolerance.tolerant_mode_enable, 1'b1);
    chk_tol(1'b0, 3'h7, 5'h10);
    $display("test table done");
    wr(7'h38, 8'hC7, 2'h3);
    chk("trim", oscillator.oscillator_trim_value, 13'h1FC7);
    wr(7'h39, 8'h1F, 2'h3);
    chk("receiver", oscillator.wake_receiver_select, 1'b0);
    wr(7'h39, 8'h9F, 2'h3);
    rd(7'h39, 8'h9F);
    chk("trim", oscillator.oscillator_trim_value, 13'h1FC7);
    @(posedge clk);
    #5;
    chk("reg_rvalid", reg_rvalid, 1'b0);
    $display("test receiver done");
    for (int c = 0; c < 8; c++)
    begin
      wr(7'h34, {4'h0, c[2:0], 1'b0}, 2'h0);
      chk_tol(1'b1, c[2:0], (c == 7) ? 5'h10 : 5'(c + 1));
      chk("bypass", tolerance.analog_filter_bypass, 1'b0);
    end
    wr(7'h34, 8'h20, 2'h0);
    chk("error_counter_active", tolerance.error_counter_active, 1'b1);
    wr(7'h34, 8'h37, 2'h0);
    chk_tol(1'b0, 3'h3, 5'h04);
    $display("test tolerance done");
    // hardware clear and software set land on the same edge
    reg_addr = 7'h34;
    reg_wdata = 8'h21;
    reg_wr = 1'b1;
    silence_expired = 1'b1;
    @(posedge clk);
    #5;
    reg_wr = 1'b0;
    silence_expired = 1'b0;
    rd(7'h34, 8'h01);
    chk("error_counter_active", tolerance.error_counter_active, 1'b1);
    $display("test silence done");
    clk_en = 1'b0;
    wr(7'h33, 8'h00, 2'h3);
    clk_en = 1'b1;
    rd(7'h33, 8'h81);
    resetn = 1'b0;
    @(posedge clk);
    #5;
    resetn = 1'b1;
    rd(7'h39, 8'h00);
    chk("payload", payload, 32'h0);
    $display("test freeze and second reset done");
    end_sim();
  end
endmodule
